// ==== srr_pkg.sv ====
// Shared constants, encodings and helpers for the step rate and ramp scaler.
package srr_pkg;

  // Byte offsets of the registers on the APB bus.
  localparam logic [7:0] SRR_OFS_CTRL     = 8'h00;
  localparam logic [7:0] SRR_OFS_CMD      = 8'h04;
  localparam logic [7:0] SRR_OFS_VMAX     = 8'h08;
  localparam logic [7:0] SRR_OFS_ACCEL    = 8'h0C;
  localparam logic [7:0] SRR_OFS_PDIV     = 8'h10;
  localparam logic [7:0] SRR_OFS_RDIV     = 8'h14;
  localparam logic [7:0] SRR_OFS_MRES     = 8'h18;
  localparam logic [7:0] SRR_OFS_TARGET   = 8'h1C;
  localparam logic [7:0] SRR_OFS_POS      = 8'h20;
  localparam logic [7:0] SRR_OFS_VEL      = 8'h24;
  localparam logic [7:0] SRR_OFS_STATUS   = 8'h28;
  localparam logic [7:0] SRR_OFS_LIMITS   = 8'h2C;

  // Field positions inside the control, status and limits registers.
  localparam int SRR_CTRL_REVERSE = 0;
  localparam int SRR_CTRL_EXTMODE = 1;
  localparam int SRR_ST_ACCEL_OK  = 0;
  localparam int SRR_ST_REFUSED   = 1;
  localparam int SRR_ST_AT_TARGET = 2;
  localparam int SRR_ST_MODE_LSB  = 4;
  localparam int SRR_LIM_UPPER    = 16;

  // Command codes written to the command register.
  localparam logic [7:0] SRR_CMD_ROTATE_CW  = 8'h01;
  localparam logic [7:0] SRR_CMD_ROTATE_CCW = 8'h02;
  localparam logic [7:0] SRR_CMD_POS_MOVE   = 8'h03;
  localparam logic [7:0] SRR_CMD_STOP       = 8'h04;

  // Reference clock is made from pclk by a fractional accumulator.
  localparam int SRR_CLK_FREQ_HZ = 25_000_000;
  localparam int SRR_REF_FREQ_HZ = 16_000_000;
  localparam int SRR_FRAC_UNIT   = 1_000_000;
  localparam logic [4:0] SRR_REF_INC = 5'(SRR_REF_FREQ_HZ / SRR_FRAC_UNIT);
  localparam logic [4:0] SRR_REF_MOD = 5'(SRR_CLK_FREQ_HZ / SRR_FRAC_UNIT);

  // Accumulator widths: 2048 * 32 = 2**16 and 2**29 / 2**16 = 2**13.
  localparam int SRR_VEL_ACC_W  = 16;
  localparam int SRR_RAMP_ACC_W = 13;

  // Ranges of the settings.
  localparam logic [10:0] SRR_WORD_MAX  = 11'h7FF;
  localparam logic [3:0]  SRR_PDIV_MAX  = 4'hD;
  localparam logic [3:0]  SRR_RDIV_MAX  = 4'hD;
  localparam logic [3:0]  SRR_MRES_MAX  = 4'h8;
  localparam int          SRR_UPPER_ADD = 12;
  localparam int          SRR_LOWER_SUB = 1;

  // Reset values of the settings.
  localparam logic [3:0]  SRR_MRES_RST  = 4'h8;
  localparam logic [3:0]  SRR_DIV_RST   = 4'h0;

  // Operating modes of the ramp generator, one-hot.
  typedef enum logic [2:0] {
    SRR_MODE_IDLE     = 3'b001,
    SRR_MODE_ROTATE   = 3'b010,
    SRR_MODE_POSITION = 3'b100
  } srr_mode_e;

  // Mask with the low exp bits set, for power-of-two division.
  function automatic logic [13:0] srr_low_mask(input logic [3:0] exp);
    srr_low_mask = 14'((15'h0001 << exp) - 15'h0001);
  endfunction

endpackage

// ==== srr_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
// Divides a tick stream by two raised to a run-time exponent.
module srr_prescaler #(
  parameter int CNT_W = 14
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              tick_in,
  input  wire logic [3:0]        exp,
  output logic                   tick_out
);
  import srr_pkg::*;

  // Whole state of the prescaler.
  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // Counts input ticks.
    logic             tick;  // Registered output pulse.
  } srr_presc_s;

  srr_presc_s st;       // Present state.
  srr_presc_s next_st;  // Next state.

  // The counter must hold the largest exponent that can be requested.
  initial
  begin
    if (CNT_W < 14)
    begin
      $error("srr_prescaler: CNT_W too small for exponent 13");
    end
  end

  // One output pulse every time the low exp bits roll over.
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (tick_in)
    begin
      // Compare before counting so exponent 0 passes every tick.
      if ((st.cnt & srr_low_mask(exp)) == srr_low_mask(exp))
      begin
        next_st.tick = 1'b1;
        next_st.cnt = '0;
      end
      else
      begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;
endmodule
`default_nettype wire

// ==== srr_scaler.sv ====
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Microstep rate is 16MHz*v/(2^pdiv*2048*32).
// - Velocity signed -2047..2047, magnitudes 0..2047.
// - Pulse divisor exponent limited to 0..13.
// - Outside external mode, full step equals microsteps over 2^mres, 0..8.
// - Ramp slope scales with 1/2^(rdiv+pdiv+29).
// - Acceleration word is unsigned 0..2047.
// - Positioning refuses acceleration outside computed limits.
// - Upper acceleration limit clamps to 2047.
// - Reverse bit inverts motor and encoder direction.
// - Reverse ignored in external step/direction mode; enc_count_invert still follows it.
module srr_scaler (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_step,
  input  wire logic        ext_dir,
  output logic             step_pulse,
  output logic             step_dir,
  output logic             full_step,
  output logic             enc_count_invert
);
  import srr_pkg::*;

  // Whole state of the block.
  typedef struct packed {
    logic [4:0]               ref_acc;     // Fractional 16 MHz generator.
    logic                     ref_en;      // One pulse per reference period.
    logic                     reverse;     // Direction reversal setting.
    logic                     ext_mode;    // External step/direction mode.
    logic [10:0]              vmax;        // Magnitude of the travel speed.
    logic [10:0]              accel;       // Acceleration word.
    logic [3:0]               pdiv;        // Pulse divisor exponent.
    logic [3:0]               rdiv;        // Ramp divisor exponent.
    logic [3:0]               mres;        // Microstep resolution exponent.
    logic [31:0]              target_pos;  // Positioning goal.
    logic [31:0]              actual_pos;  // Microstep position counter.
    logic signed [11:0]       vel;         // Present signed velocity.
    logic signed [11:0]       cmd_vel;     // Velocity asked by rotation.
    srr_mode_e                mode;        // Ramp generator mode.
    logic [SRR_VEL_ACC_W-1:0] vel_acc;     // Step accumulator.
    logic [SRR_RAMP_ACC_W-1:0] ramp_acc;   // Ramp accumulator.
    logic [31:0]              accel_steps; // Steps spent accelerating.
    logic [7:0]               ustep_cnt;   // Microsteps within a full step.
    logic                     refused;     // Sticky refused move flag.
    logic                     at_target;   // Last move reached its goal.
    logic [1:0]               xstep_sync;  // Synchroniser for ext_step.
    logic                     xstep_last;  // Previous synchronised ext_step.
    logic [1:0]               xdir_sync;   // Synchroniser for ext_dir.
    logic                     step_out;    // Step pulse output.
    logic                     dir_out;     // Direction output.
    logic                     full_out;    // Full step output.
    logic                     ready;       // APB ready.
    logic                     slverr;      // APB error.
    logic [31:0]              rdata;       // APB read data.
  } srr_state_s;

  srr_state_s st;       // Present state.
  srr_state_s next_st;  // Next state.

  logic pulse_tick;  // Reference divided by 2^pdiv.
  logic ramp_tick;   // Reference divided by 2^rdiv.

  // Pulse rate prescaler.
  srr_prescaler #(.CNT_W(14)) u_pulse_presc (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (st.ref_en),
    .exp      (st.pdiv),
    .tick_out (pulse_tick)
  );

  // Ramp rate prescaler.
  srr_prescaler #(.CNT_W(14)) u_ramp_presc (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (st.ref_en),
    .exp      (st.rdiv),
    .tick_out (ramp_tick)
  );

  // Tells whether an address selects a register.
  function automatic logic srr_addr_known(input logic [7:0] a);
    srr_addr_known = (a[1:0] == 2'b00) && (a <= SRR_OFS_LIMITS);
  endfunction

  // Saturates an exponent to its largest legal value.
  function automatic logic [3:0] srr_sat(input logic [31:0] v, input logic [3:0] mx);
    srr_sat = (v > 32'(mx)) ? mx : v[3:0];
  endfunction

  // Lower and upper acceleration limits for positioning moves.
  logic signed [5:0] div_diff;   // Ramp minus pulse exponent.
  logic [10:0]       acc_lower;  // Smallest usable acceleration.
  logic [10:0]       acc_upper;  // Largest usable acceleration.
  logic              accel_ok;   // Acceleration lies within the limits.
  always_comb
  begin
    div_diff = 6'(signed'({2'b00, st.rdiv})) - 6'(signed'({2'b00, st.pdiv}));
    // A fractional lower bound is met by any word of one or more.
    acc_lower = (div_diff <= 6'(SRR_LOWER_SUB)) ? 11'h001 :
      11'(12'h001 << (div_diff - 6'(SRR_LOWER_SUB)));
    // An upper bound at or above eleven bits is clamped to the word range.
    if (div_diff + 6'(SRR_UPPER_ADD) >= 6'sd11)
    begin
      acc_upper = SRR_WORD_MAX;
    end
    else if (div_diff + 6'(SRR_UPPER_ADD) < 6'sd0)
    begin
      acc_upper = 11'h000;
    end
    else
    begin
      acc_upper = 11'((12'h001 << (div_diff + 6'(SRR_UPPER_ADD))) - 12'h001);
    end
    // A lower bound beyond eleven bits leaves no usable word at all.
    accel_ok = (div_diff - 6'(SRR_LOWER_SUB) < 6'sd11) &&
      (st.accel >= acc_lower) && (st.accel <= acc_upper);
  end

  // Remaining distance and velocity magnitude for the ramp generator.
  logic signed [31:0] remain;      // Signed distance to the goal.
  logic [31:0]        remain_abs;  // Its magnitude.
  logic [10:0]        vel_mag;     // Magnitude of the present velocity.
  logic signed [11:0] ramp_goal;   // Velocity the ramp heads for.
  logic               decel;       // Positioning move must slow down.
  always_comb
  begin
    remain = signed'(st.target_pos - st.actual_pos);
    remain_abs = remain[31] ? 32'(-remain) : 32'(remain);
    vel_mag = st.vel[11] ? 11'(-st.vel) : 11'(st.vel);
    decel = remain_abs <= st.accel_steps;
    ramp_goal = 12'sd0;
    case (st.mode)
      SRR_MODE_ROTATE: ramp_goal = st.cmd_vel;
      SRR_MODE_POSITION:
      begin
        // While braking keep a crawl of one unit so the goal is reached.
        if (decel)
        begin
          ramp_goal = remain[31] ? -12'sd1 : 12'sd1;
        end
        else
        begin
          ramp_goal = remain[31] ? -signed'({1'b0, st.vmax}) : signed'({1'b0, st.vmax});
        end
      end
      default: ramp_goal = 12'sd0;
    endcase
  end

  // Next-state logic for the bus, the ramp and the step generator.
  logic [SRR_VEL_ACC_W:0]   vel_sum;   // Step accumulator with carry.
  logic [SRR_RAMP_ACC_W:0]  ramp_sum;  // Ramp accumulator with carry.
  logic                     int_step;  // Internal microstep this cycle.
  logic                     int_dir;   // Internal direction, high forward.
  logic                     wr_en;     // APB write completes.
  logic                     ext_edge;  // Rising edge of external step.
  logic [5:0]               ref_sum;   // Reference accumulator with carry room.
  always_comb
  begin
    next_st = st;
    vel_sum = '0;
    ramp_sum = '0;
    int_step = 1'b0;
    int_dir = ~st.vel[11];
    wr_en = psel && penable && st.ready && pwrite;
    ext_edge = st.xstep_sync[1] && !st.xstep_last;

    // Pins pass two flip-flops before anything looks at them.
    next_st.xstep_sync = {st.xstep_sync[0], ext_step};
    next_st.xdir_sync = {st.xdir_sync[0], ext_dir};
    next_st.xstep_last = st.xstep_sync[1];

    // The 16 MHz reference: add 16 per pclk cycle, wrap at 25.
    ref_sum = {1'b0, st.ref_acc} + {1'b0, SRR_REF_INC};
    next_st.ref_en = (ref_sum >= {1'b0, SRR_REF_MOD});
    next_st.ref_acc = next_st.ref_en ? 5'(ref_sum - {1'b0, SRR_REF_MOD}) : ref_sum[4:0];

    // Velocity ramp: the accumulator adds the acceleration word at the
    // reference over 2^rdiv, each wrap moves the velocity one unit.
    if (ramp_tick && st.vel != ramp_goal)
    begin
      ramp_sum = {1'b0, st.ramp_acc} + {3'b000, st.accel};
      next_st.ramp_acc = ramp_sum[SRR_RAMP_ACC_W-1:0];
      if (ramp_sum[SRR_RAMP_ACC_W])
      begin
        next_st.vel = (st.vel < ramp_goal) ? st.vel + 12'sd1 : st.vel - 12'sd1;
      end
    end

    // Step generator: add the speed at the reference over 2^pdiv.
    if (pulse_tick && !st.mode[0])
    begin
      vel_sum = {1'b0, st.vel_acc} + {6'b000000, vel_mag};
      next_st.vel_acc = vel_sum[SRR_VEL_ACC_W-1:0];
      int_step = vel_sum[SRR_VEL_ACC_W];
    end

    // A positioning move ends on its goal, never past it.
    if (st.mode == SRR_MODE_POSITION && remain_abs == 32'h0)
    begin
      int_step = 1'b0;
      next_st.vel = 12'sd0;
      next_st.mode = SRR_MODE_IDLE;
      next_st.at_target = 1'b1;
    end

    // Microstep bookkeeping.
    if (int_step)
    begin
      next_st.actual_pos = int_dir ? st.actual_pos + 32'h1 : st.actual_pos - 32'h1;
      next_st.ustep_cnt = st.ustep_cnt + 8'h01;
      if (st.mode == SRR_MODE_POSITION && !decel && vel_mag < st.vmax)
      begin
        next_st.accel_steps = st.accel_steps + 32'h1;
      end
    end

    // Outputs: internal steps with optional reversal, or the pins as they are.
    if (st.ext_mode)
    begin
      next_st.step_out = ext_edge;
      next_st.dir_out = st.xdir_sync[1];
      next_st.full_out = 1'b0;
    end
    else
    begin
      next_st.step_out = int_step;
      next_st.dir_out = int_dir ^ st.reverse;
      next_st.full_out = int_step &&
        ((st.ustep_cnt & 8'(srr_low_mask(st.mres))) == 8'(srr_low_mask(st.mres)));
    end

    // APB: one wait state, read data and error are registered.
    next_st.ready = psel && penable && !st.ready;
    next_st.slverr = psel && penable && !st.ready && !srr_addr_known(paddr);
    if (psel && penable && !st.ready)
    begin
      case (paddr)
        SRR_OFS_CTRL:   next_st.rdata = 32'({st.ext_mode, st.reverse});
        SRR_OFS_VMAX:   next_st.rdata = 32'(st.vmax);
        SRR_OFS_ACCEL:  next_st.rdata = 32'(st.accel);
        SRR_OFS_PDIV:   next_st.rdata = 32'(st.pdiv);
        SRR_OFS_RDIV:   next_st.rdata = 32'(st.rdiv);
        SRR_OFS_MRES:   next_st.rdata = 32'(st.mres);
        SRR_OFS_TARGET: next_st.rdata = st.target_pos;
        SRR_OFS_POS:    next_st.rdata = st.actual_pos;
        SRR_OFS_VEL:    next_st.rdata = 32'(signed'(st.vel));
        SRR_OFS_STATUS:
        begin
          next_st.rdata = '0;
          next_st.rdata[SRR_ST_ACCEL_OK] = accel_ok;
          next_st.rdata[SRR_ST_REFUSED] = st.refused;
          next_st.rdata[SRR_ST_AT_TARGET] = st.at_target;
          next_st.rdata[SRR_ST_MODE_LSB +: 3] = st.mode;
        end
        SRR_OFS_LIMITS: next_st.rdata = 32'({5'h00, acc_upper, 5'h00, acc_lower});
        default:        next_st.rdata = '0;
      endcase
    end

    // Register writes take effect at the completing edge.
    if (wr_en)
    begin
      case (paddr)
        SRR_OFS_CTRL:
        begin
          next_st.reverse = pwdata[SRR_CTRL_REVERSE];
          next_st.ext_mode = pwdata[SRR_CTRL_EXTMODE];
        end
        SRR_OFS_VMAX:   next_st.vmax = pwdata[10:0];
        SRR_OFS_ACCEL:  next_st.accel = pwdata[10:0];
        SRR_OFS_PDIV:   next_st.pdiv = srr_sat(pwdata, SRR_PDIV_MAX);
        SRR_OFS_RDIV:   next_st.rdiv = srr_sat(pwdata, SRR_RDIV_MAX);
        SRR_OFS_MRES:   next_st.mres = srr_sat(pwdata, SRR_MRES_MAX);
        SRR_OFS_TARGET: next_st.target_pos = pwdata;
        SRR_OFS_STATUS:
        begin
          // Write one to clear; a refusal needs a command write, so the two never meet in one cycle.
          if (pwdata[SRR_ST_REFUSED])
          begin
            next_st.refused = 1'b0;
          end
        end
        SRR_OFS_CMD:
        begin
          case (pwdata[7:0])
            SRR_CMD_ROTATE_CW:
            begin
              // Velocity mode is not bound by the positioning limits.
              next_st.cmd_vel = signed'({1'b0, st.vmax});
              next_st.mode = SRR_MODE_ROTATE;
              next_st.at_target = 1'b0;
            end
            SRR_CMD_ROTATE_CCW:
            begin
              next_st.cmd_vel = -signed'({1'b0, st.vmax});
              next_st.mode = SRR_MODE_ROTATE;
              next_st.at_target = 1'b0;
            end
            SRR_CMD_POS_MOVE:
            begin
              if (accel_ok)
              begin
                next_st.mode = SRR_MODE_POSITION;
                next_st.accel_steps = '0;
                next_st.at_target = 1'b0;
              end
              else
              begin
                next_st.refused = 1'b1;
              end
            end
            SRR_CMD_STOP:
            begin
              // Ramp down to rest at the programmed acceleration.
              next_st.cmd_vel = 12'sd0;
              next_st.mode = SRR_MODE_ROTATE;
            end
            default: next_st.refused = st.refused;
          endcase
        end
        default: next_st.reverse = st.reverse;
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.mode <= SRR_MODE_IDLE;
      st.mres <= SRR_MRES_RST;
      st.pdiv <= SRR_DIV_RST;
      st.rdiv <= SRR_DIV_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Every output comes straight from the state register.
  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.slverr;
  assign step_pulse = st.step_out;
  assign step_dir = st.dir_out;
  assign full_step = st.full_out;
  assign enc_count_invert = st.reverse;
endmodule
`default_nettype wire

// ==== srr_scaler_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the bus handshake and the step outputs of the scaler.
module srr_scaler_checker
  import srr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        ext_step,
  input  wire logic        ext_dir,
  input  wire logic        step_pulse,
  input  wire logic        step_dir,
  input  wire logic        full_step,
  input  wire logic        enc_count_invert
);
  logic wr_ctrl;  // A control write is taken at this edge.
  logic rev_q;    // Reverse bit as last written.
  logic ext_q;    // External mode bit as last written.
  assign wr_ctrl = psel && penable && pready && pwrite && (paddr == SRR_OFS_CTRL);
  // Mirrors the control bits so the outputs can be judged against them.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rev_q <= 1'b0;
      ext_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      rev_q <= pwdata[SRR_CTRL_REVERSE];
      ext_q <= pwdata[SRR_CTRL_EXTMODE];
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  AST_READY_AFTER: assert property ($rose(penable) && psel |=> pready)
    else $error("pready missing in second access cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_UNMAPPED: assert property
    (pready && (paddr > SRR_OFS_LIMITS || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  AST_STEP_ONE: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse wider than one cycle");
  AST_FULL_WITH_STEP: assert property (full_step |-> step_pulse)
    else $error("full step without microstep");
  AST_ENC_INVERT: assert property (wr_ctrl |-> ##2 (enc_count_invert == rev_q))
    else $error("encoder invert does not follow reverse bit");
  AST_EXT_LATENCY: assert property (ext_q && $rose(ext_step) |-> ##[2:4] step_pulse)
    else $error("external step not passed on");
  AST_EXT_NO_FULL: assert property (ext_q && $past(ext_q) |-> !full_step)
    else $error("full step in external mode");
  AST_EXT_DIR: assert property
    (ext_q && $past(ext_q) && step_pulse |-> step_dir == $past(ext_dir, 3))
    else $error("direction altered in external mode");
  // Main scenarios reached.
  cover property (step_pulse && full_step);
  cover property (pready && pslverr);
  cover property (ext_q && step_pulse);
endmodule
bind srr_scaler srr_scaler_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_step(ext_step), .ext_dir(ext_dir), .step_pulse(step_pulse), .step_dir(step_dir),
  .full_step(full_step), .enc_count_invert(enc_count_invert)
);
`default_nettype wire

// ==== srr_motor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Driver stage stand-in: tallies the microsteps and full steps it receives.
module srr_motor_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clr,
  input  wire logic        step_pulse,
  input  wire logic        full_step,
  output logic [15:0]      steps,
  output logic [15:0]      fulls
);
  // The bench clears the tallies between measurements.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      steps <= 16'h0;
      fulls <= 16'h0;
    end
    else
    begin
      steps <= clr ? 16'h0 : steps + 16'(step_pulse);
      fulls <= clr ? 16'h0 : fulls + 16'(full_step);
    end
endmodule
`default_nettype wire

// ==== srr_scaler_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the step rate and ramp scaler.
module srr_scaler_test;
  import srr_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ext_step = 1'b0;
  logic        ext_dir = 1'b0;
  logic        clr = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        step_pulse;
  logic        step_dir;
  logic        full_step;
  logic        enc_count_invert;
  logic [15:0] steps;
  logic [15:0] fulls;
  int          miscompares = 0;
  int          num_checks = 0;
  logic [33:0] notes[$];        // Expected {write, error, data} per transfer.
  logic [33:0] note;
  logic [15:0] lfsr = 16'hF152;
  logic [31:0] val;
  logic [7:0]  pr[4] = '{8'h50, 8'h00, 8'h03, 8'h80};  // Pulse and ramp exponent pairs.

  initial forever #20 pclk = ~pclk;

  srr_scaler DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_step(ext_step), .ext_dir(ext_dir), .step_pulse(step_pulse),
    .step_dir(step_dir), .full_step(full_step), .enc_count_invert(enc_count_invert));
  srr_motor_model u_motor (.pclk(pclk), .presetn(presetn), .clr(clr),
    .step_pulse(step_pulse), .full_step(full_step), .steps(steps), .fulls(fulls));

  // Next state of the stimulus shift register.
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected acceleration window, upper limit in the high half.
  function automatic logic [31:0] lims(input int p, input int r);
    int d;
    int lo;
    int up;
    d = r - p;
    lo = (d < 1) ? 1 : (1 << (d - 1));
    up = (d > -1) ? 2047 : ((1 << (d + 12)) - 1);
    return 32'((up << 16) | lo);
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // One bus transfer; the expected answer is noted before it starts.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e, input logic [31:0] x);
    notes.push_back({w, e, x});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 1'b0, x);
  endtask

  task automatic tally_clear();
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask

  // Takes the oldest note whenever the slave answers.
  always @(posedge pclk)
    if (pready === 1'b1 && notes.size() > 0)
    begin
      note = notes.pop_front();
      cmp({31'h0, pslverr}, {31'h0, note[32]});
      if (!note[33])
        cmp(prdata, note[31:0]);
    end

  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial
  begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(SRR_OFS_CTRL, 32'h0);
    rd(SRR_OFS_MRES, 32'h8);
    apb(1'b0, 8'h30, 32'h0, 1'b1, 32'h0);
    apb(1'b1, 8'h06, 32'h1, 1'b1, 32'h0);
    wr(SRR_OFS_PDIV, 32'hF);
    rd(SRR_OFS_PDIV, 32'hD);
    wr(SRR_OFS_MRES, 32'hF);
    rd(SRR_OFS_MRES, 32'h8);
    wr(SRR_OFS_VMAX, 32'hFFFF);
    rd(SRR_OFS_VMAX, 32'h7FF);
    wr(SRR_OFS_ACCEL, 32'hFFFF);
    rd(SRR_OFS_ACCEL, 32'h7FF);
    for (int i = 0; i < 3; i++)
    begin
      lfsr = nxt(lfsr);
      val = {lfsr, nxt(lfsr)};
      wr(SRR_OFS_TARGET, val);
      rd(SRR_OFS_TARGET, val);
    end
    foreach (pr[i])
    begin
      wr(SRR_OFS_PDIV, 32'(pr[i][7:4]));
      wr(SRR_OFS_RDIV, 32'(pr[i][3:0]));
      rd(SRR_OFS_LIMITS, lims(pr[i][7:4], pr[i][3:0]));
    end
    wr(SRR_OFS_PDIV, 32'h5);
    wr(SRR_OFS_RDIV, 32'h0);
    wr(SRR_OFS_TARGET, 32'h64);
    wr(SRR_OFS_ACCEL, 32'hC8);
    wr(SRR_OFS_CMD, 32'(SRR_CMD_POS_MOVE));
    rd(SRR_OFS_STATUS, 32'h12);
    wr(SRR_OFS_STATUS, 32'h2);
    wr(SRR_OFS_ACCEL, 32'h64);
    wr(SRR_OFS_CMD, 32'(SRR_CMD_POS_MOVE));
    rd(SRR_OFS_STATUS, 32'h41);
    wr(SRR_OFS_ACCEL, 32'hC8);
    wr(SRR_OFS_CMD, 32'(SRR_CMD_ROTATE_CW));
    rd(SRR_OFS_STATUS, 32'h20);
    wr(SRR_OFS_CMD, 32'(SRR_CMD_STOP));
    repeat (3000) @(posedge pclk);
    wr(SRR_OFS_PDIV, 32'h0);
    wr(SRR_OFS_MRES, 32'h2);
    wr(SRR_OFS_ACCEL, 32'h7FF);
    wr(SRR_OFS_VMAX, 32'h7FF);
    wr(SRR_OFS_CMD, 32'(SRR_CMD_ROTATE_CW));
    repeat (14000) @(posedge pclk);
    rd(SRR_OFS_VEL, 32'h7FF);
    tally_clear();
    repeat (6400) @(posedge pclk);
    cmp_rng(steps, 16'h7E, 16'h82);
    cmp_rng(fulls, 16'h1E, 16'h21);
    cmp({31'h0, step_dir}, 32'h1);
    wr(SRR_OFS_CTRL, 32'h1);
    repeat (100) @(posedge pclk);
    cmp({31'h0, step_dir}, 32'h0);
    cmp({31'h0, enc_count_invert}, 32'h1);
    wr(SRR_OFS_CMD, 32'(SRR_CMD_STOP));
    repeat (14000) @(posedge pclk);
    rd(SRR_OFS_VEL, 32'h0);
    wr(SRR_OFS_VMAX, 32'h40);
    wr(SRR_OFS_CMD, 32'(SRR_CMD_ROTATE_CCW));
    repeat (2000) @(posedge pclk);
    rd(SRR_OFS_VEL, 32'hFFFFFFC0);
    cmp({31'h0, step_dir}, 32'h1);
    wr(SRR_OFS_CMD, 32'(SRR_CMD_STOP));
    repeat (1000) @(posedge pclk);
    ext_dir <= 1'b1;
    wr(SRR_OFS_CTRL, 32'h3);
    tally_clear();
    repeat (4)
    begin
      ext_step <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_step <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    cmp_rng(steps, 16'h4, 16'h4);
    cmp_rng(fulls, 16'h0, 16'h0);
    cmp({31'h0, step_dir}, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
